// [rtl/blit_geom_pkg.sv]
// constants for the block-transfer geometry register bank
package blit_geom_pkg;
	localparam int addr_w = 12;
	localparam int dest_w = 21;
	localparam int offs_w = 11;
	localparam int dim_w = 10;
	// register indices; the byte address on the bus is four times the index
	localparam logic [9:0] idx_ctrl = 10'h100;
	localparam logic [9:0] idx_depth = 10'h101;
	localparam logic [9:0] idx_src_lo = 10'h104;
	localparam logic [9:0] idx_src_mid = 10'h105;
	localparam logic [9:0] idx_src_hi = 10'h106;
	localparam logic [9:0] idx_dest_lo = 10'h108;
	localparam logic [9:0] idx_dest_mid = 10'h109;
	localparam logic [9:0] idx_dest_hi = 10'h10a;
	localparam logic [9:0] idx_offs_lo = 10'h10c;
	localparam logic [9:0] idx_offs_hi = 10'h10d;
	localparam logic [9:0] idx_width_lo = 10'h110;
	localparam logic [9:0] idx_width_hi = 10'h111;
	localparam logic [9:0] idx_height_lo = 10'h112;
	localparam logic [9:0] idx_height_hi = 10'h113;
	// field positions in the control and depth registers
	localparam int ctrl_start_bit = 0;
	localparam int ctrl_pattern_bit = 1;
	localparam int ctrl_busy_bit = 7;
	localparam int depth_bit = 0;
	// reset values
	localparam logic [20:0] rst_addr = 21'h000000;
	localparam logic [10:0] rst_offs = 11'h000;
	localparam logic [9:0] rst_dim = 10'h000;
endpackage : blit_geom_pkg

// [rtl/pattern_addr_split.sv]
// splits the source start address into pattern base, line and pixel offset
`timescale 1ns/10ps
`default_nettype none
module pattern_addr_split
(
	input wire logic [20:0] src_addr,
	input wire logic depth16,
	output logic [14:0] pat_base,
	output logic [2:0] pat_line,
	output logic [3:0] pat_pix
);
	always_comb
	begin
		if (depth16)
		begin
			pat_base = {1'b0, src_addr[20:7]};
			pat_line = src_addr[6:4];
			pat_pix = src_addr[3:0];
		end
		else
		begin
			pat_base = src_addr[20:6];
			pat_line = src_addr[5:3];
			pat_pix = {1'b0, src_addr[2:0]};
		end
	end
endmodule : pattern_addr_split
`default_nettype wire

// [rtl/blit_geometry_registers.sv]
// geometry registers and rectangular address generator of the block-transfer engine
// Operation
// - the destination start address is 21 bits over three byte registers, the top one holding bits 20..16 low.
// - an 11-bit word offset gives the distance from the first word of one line to that of the next.
// - the line word offset feeds only rectangular transfer addressing, never display refresh.
// - the 10-bit width field is pixels minus one, so each line handles the stored value plus one pixels.
// - the 10-bit height field is lines minus one, so the stored value plus one lines are handled.
// - at 8 bpp a pattern fill takes base from source bits 20:6, line from 5:3 and pixel from 2:0.
// - at 16 bpp a pattern fill takes base from source bits 20:7, line from 6:4 and pixel from 3:0.
// - a colour depth bit of one selects 16 bpp and zero selects 8 bpp.
`timescale 1ns/10ps
`default_nettype none
module blit_geometry_registers
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [blit_geom_pkg::addr_w-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic gen_valid,
	output logic [20:0] gen_word_addr,
	output logic gen_byte_lane,
	output logic gen_busy,
	output logic pattern_mode,
	output logic depth16,
	output logic [14:0] pat_base,
	output logic [2:0] pat_line,
	output logic [3:0] pat_pix
);
	import blit_geom_pkg::*;

	typedef struct packed {
		logic [20:0] dest;
		logic [10:0] offs;
		logic [9:0] width;
		logic [9:0] height;
		logic [20:0] src;
		logic depth;
		logic pattern;
		logic busy;
		logic [9:0] pix;
		logic [9:0] line;
		logic [20:0] line_start;
		logic valid;
		logic [20:0] word_addr;
		logic lane;
		logic wait_n;
		logic [7:0] rdata;
		logic [14:0] pbase;
		logic [2:0] pline;
		logic [3:0] ppix;
	} state_s;

	state_s st_r;
	state_s st_nxt;
	logic [9:0] idx;
	logic [14:0] split_base;
	logic [2:0] split_line;
	logic [3:0] split_pix;
	logic [7:0] rd_val;
	logic [7:0] wd;
	logic [20:0] pix_words;

	assign idx = avs_address[11:2];
	assign wd = avs_writedata[7:0];

	pattern_addr_split u_split
	(
		.src_addr(st_r.src),
		.depth16(st_r.depth),
		.pat_base(split_base),
		.pat_line(split_line),
		.pat_pix(split_pix)
	);

	// read multiplexer; unmapped indices read as zero
	always_comb
	begin
		case (idx)
			idx_ctrl: rd_val = {st_r.busy, 5'h00, st_r.pattern, 1'b0};
			idx_depth: rd_val = {7'h00, st_r.depth};
			idx_src_lo: rd_val = st_r.src[7:0];
			idx_src_mid: rd_val = st_r.src[15:8];
			idx_src_hi: rd_val = {3'h0, st_r.src[20:16]};
			idx_dest_lo: rd_val = st_r.dest[7:0];
			idx_dest_mid: rd_val = st_r.dest[15:8];
			idx_dest_hi: rd_val = {3'h0, st_r.dest[20:16]};
			idx_offs_lo: rd_val = st_r.offs[7:0];
			idx_offs_hi: rd_val = {5'h00, st_r.offs[10:8]};
			idx_width_lo: rd_val = st_r.width[7:0];
			idx_width_hi: rd_val = {6'h00, st_r.width[9:8]};
			idx_height_lo: rd_val = st_r.height[7:0];
			idx_height_hi: rd_val = {6'h00, st_r.height[9:8]};
			default: rd_val = 8'h00;
		endcase
	end

	// at 8 bpp two pixels share a word, at 16 bpp each pixel has one
	assign pix_words = st_r.depth ? 21'(st_r.pix) : 21'(st_r.pix[9:1]);

	always_comb
	begin
		st_nxt = st_r;
		// bus: one idle-wait cycle to register read data, then waitrequest low for one edge
		if (st_r.wait_n)
		begin
			st_nxt.wait_n = 1'b0;
		end
		else if (avs_read || avs_write)
		begin
			st_nxt.wait_n = 1'b1;
			st_nxt.rdata = rd_val;
		end
		// writes land only on the edge that sees waitrequest low
		if (st_r.wait_n && avs_write)
		begin
			case (idx)
				idx_ctrl: st_nxt.pattern = wd[ctrl_pattern_bit];
				idx_depth: st_nxt.depth = wd[depth_bit];
				idx_src_lo: st_nxt.src[7:0] = wd;
				idx_src_mid: st_nxt.src[15:8] = wd;
				idx_src_hi: st_nxt.src[20:16] = wd[4:0];
				idx_dest_lo: st_nxt.dest[7:0] = wd;
				idx_dest_mid: st_nxt.dest[15:8] = wd;
				idx_dest_hi: st_nxt.dest[20:16] = wd[4:0];
				idx_offs_lo: st_nxt.offs[7:0] = wd;
				idx_offs_hi: st_nxt.offs[10:8] = wd[2:0];
				idx_width_lo: st_nxt.width[7:0] = wd;
				idx_width_hi: st_nxt.width[9:8] = wd[1:0];
				idx_height_lo: st_nxt.height[7:0] = wd;
				idx_height_hi: st_nxt.height[9:8] = wd[1:0];
				default: st_nxt.pattern = st_r.pattern;
			endcase
		end
		// address generator; one pixel per clock, geometry read live so keep it still while busy
		st_nxt.valid = st_r.busy;
		st_nxt.word_addr = st_r.line_start + pix_words;
		st_nxt.lane = st_r.depth ? 1'b0 : st_r.pix[0];
		if (st_r.busy)
		begin
			if (st_r.pix == st_r.width)
			begin
				st_nxt.pix = 10'h000;
				if (st_r.line == st_r.height)
				begin
					st_nxt.busy = 1'b0;
				end
				else
				begin
					st_nxt.line = st_r.line + 10'h001;
					// the offset is applied here and nowhere else
					st_nxt.line_start = st_r.line_start + 21'(st_r.offs);
				end
			end
			else
			begin
				st_nxt.pix = st_r.pix + 10'h001;
			end
		end
		else if (st_r.wait_n && avs_write && idx == idx_ctrl && wd[ctrl_start_bit])
		begin
			st_nxt.busy = 1'b1;
			st_nxt.pix = 10'h000;
			st_nxt.line = 10'h000;
			st_nxt.line_start = st_r.dest;
		end
		st_nxt.pbase = split_base;
		st_nxt.pline = split_line;
		st_nxt.ppix = split_pix;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= '0;
			st_r.dest <= rst_addr;
			st_r.src <= rst_addr;
			st_r.line_start <= rst_addr;
			st_r.offs <= rst_offs;
			st_r.width <= rst_dim;
			st_r.height <= rst_dim;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign avs_readdata = {24'h000000, st_r.rdata};
	assign avs_waitrequest = ~st_r.wait_n;
	assign gen_valid = st_r.valid;
	assign gen_word_addr = st_r.word_addr;
	assign gen_byte_lane = st_r.lane;
	assign gen_busy = st_r.busy;
	assign pattern_mode = st_r.pattern;
	assign depth16 = st_r.depth;
	assign pat_base = st_r.pbase;
	assign pat_line = st_r.pline;
	assign pat_pix = st_r.ppix;
endmodule : blit_geometry_registers
`default_nettype wire

// [tb/blit_geometry_registers_chk.sv]
// port assertions for the geometry register bank
`timescale 1ns/10ps
`default_nettype none
module blit_geometry_registers_chk
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	input wire logic gen_valid,
	input wire logic gen_busy,
	input wire logic gen_byte_lane,
	input wire logic depth16,
	input wire logic [14:0] pat_base,
	input wire logic [3:0] pat_pix
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_one_wait; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait low too long");
	property p_ans; $rose(avs_read) |=> !avs_waitrequest; endproperty
	a_ans: assert property (p_ans) else $error("read not answered");
	property p_rd_hi; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
	// split lags the depth bit, so wait two cycles
	property p_pix8; !depth16 && !$past(depth16) && !$past(depth16, 2) |-> !pat_pix[3]; endproperty
	a_pix8: assert property (p_pix8) else $error("pixel bit 3 set at 8 bpp");
	property p_base16; depth16 && $past(depth16) && $past(depth16, 2) |-> !pat_base[14]; endproperty
	a_base16: assert property (p_base16) else $error("base bit 14 set at 16 bpp");
	property p_lane16; gen_valid && depth16 |-> !gen_byte_lane; endproperty
	a_lane16: assert property (p_lane16) else $error("lane set at 16 bpp");
	property p_start; $rose(gen_busy) |=> gen_valid; endproperty
	a_start: assert property (p_start) else $error("no address after start");
	property p_run; $fell(gen_valid) |-> !gen_busy; endproperty
	a_run: assert property (p_run) else $error("busy after last address");
	property p_valid; gen_valid |-> gen_busy || $past(gen_busy); endproperty
	a_valid: assert property (p_valid) else $error("address while idle");
endmodule : blit_geometry_registers_chk
bind blit_geometry_registers blit_geometry_registers_chk u_chk (.sys_clk, .rst, .avs_read, .avs_waitrequest,
	.avs_readdata, .gen_valid, .gen_busy, .gen_byte_lane, .depth16, .pat_base, .pat_pix);
`default_nettype wire

// [tb/blit_geometry_registers_tb.sv]
// self-checking bench for the geometry register bank
`timescale 1ns/10ps
`default_nettype none
module blit_geometry_registers_tb;
	import blit_geom_pkg::*;
	logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, gen_valid, gen_byte_lane, gen_busy;
	logic pattern_mode, depth16;
	logic [addr_w-1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [20:0] gen_word_addr;
	logic [14:0] pat_base;
	logic [2:0] pat_line;
	logic [3:0] pat_pix;
	int fails, checked, cyc;
	blit_geometry_registers u_dut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .gen_valid, .gen_word_addr, .gen_byte_lane, .gen_busy,
		.pattern_mode, .depth16, .pat_base, .pat_line, .pat_pix);
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task print_verdict;
		if (fails == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			print_verdict;
		end
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	// wait low is judged at the rising edge itself, where read data also stands
	task acc(input logic w, input logic [9:0] i, input logic [7:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		avs_address <= {i, 2'b00};
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : acc
	task wr(input logic [9:0] i, input logic [7:0] d);
		logic [31:0] q;
		acc(1'b1, i, d, q);
	endtask : wr
	task t_regs;
		logic [9:0] ix[10] = '{idx_dest_lo, idx_dest_mid, idx_dest_hi, idx_offs_lo, idx_offs_hi,
			idx_width_lo, idx_width_hi, idx_height_lo, idx_height_hi, 10'h1ff};
		logic [7:0] mk[10] = '{8'hff, 8'hff, 8'h1f, 8'hff, 8'h07, 8'hff, 8'h03, 8'hff, 8'h03, 8'h00};
		logic [31:0] q;
		for (int k = 0; k < 10; k++)
		begin
			acc(1'b0, ix[k], 8'h00, q);
			check(q, 32'h0);
			wr(ix[k], 8'hff);
			acc(1'b0, ix[k], 8'h00, q);
			check(q, {24'h0, mk[k]});
		end
	endtask : t_regs
	task t_pat(input logic [20:0] s);
		logic [31:0] q;
		wr(idx_ctrl, 8'h02);
		repeat (2) @(negedge sys_clk);
		check(pattern_mode, 1'b1);
		acc(1'b0, idx_ctrl, 8'h00, q);
		check(q, 32'h2);
		wr(idx_ctrl, 8'h00);
		repeat (2) @(negedge sys_clk);
		check(pattern_mode, 1'b0);
		wr(idx_src_lo, s[7:0]);
		wr(idx_src_mid, s[15:8]);
		wr(idx_src_hi, {3'h0, s[20:16]});
		for (int d = 0; d < 2; d++)
		begin
			wr(idx_depth, 8'(d));
			repeat (3) @(negedge sys_clk);
			check(depth16, d);
			check(pat_base, d ? s[20:7] : s[20:6]);
			check(pat_line, d ? s[6:4] : s[5:3]);
			check(pat_pix, d ? s[3:0] : s[2:0]);
		end
	endtask : t_pat
	task t_xfer(input logic d, input logic [9:0] w, input logic [9:0] h, input logic [20:0] a,
		input logic [10:0] o);
		int l, p, n;
		wr(idx_depth, {7'h0, d});
		wr(idx_dest_lo, a[7:0]);
		wr(idx_dest_mid, a[15:8]);
		wr(idx_dest_hi, {3'h0, a[20:16]});
		wr(idx_offs_lo, o[7:0]);
		wr(idx_offs_hi, {5'h0, o[10:8]});
		wr(idx_width_lo, w[7:0]);
		wr(idx_width_hi, {6'h0, w[9:8]});
		wr(idx_height_lo, h[7:0]);
		wr(idx_height_hi, {6'h0, h[9:8]});
		wr(idx_ctrl, 8'h01);
		l = 0;
		p = 0;
		n = 0;
		repeat (300)
		begin
			@(negedge sys_clk);
			if (gen_valid === 1'b1)
			begin
				check(gen_word_addr, a + l * o + (d ? p : p / 2));
				check(gen_byte_lane, d ? 0 : p % 2);
				n++;
				p = (p == w) ? 0 : p + 1;
				l = (p == 0) ? l + 1 : l;
			end
		end
		check(n, (w + 1) * (h + 1));
	endtask : t_xfer
	initial
	begin
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = '0;
		avs_writedata = '0;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs;
		t_pat(21'h1a5b6d);
		t_xfer(1'b1, 10'd1, 10'd2, 21'h1abcd, 11'h7ff);
		t_xfer(1'b0, 10'd3, 10'd1, 21'h100000, 11'h040);
		t_xfer(1'b1, 10'd0, 10'd0, 21'h000010, 11'h000);
		print_verdict;
	end
endmodule : blit_geometry_registers_tb
`default_nettype wire
